// ### rtl/pfc_protection_supervisor.sv
// Start-up and protection supervisor for a boost PFC switch.
`timescale 1ns/1ns
module pfc_protection_supervisor
   import pfc_pkg::*;
#(
   parameter int SOFT_STOP_CYC_P = pfc_pkg::SOFT_STOP_CYC,
   parameter int DROPOUT_CYC_P = pfc_pkg::DROPOUT_CYC,
   parameter int DEBOUNCE_CYC_P = pfc_pkg::DEBOUNCE_CYC,
   parameter int DEBOUNCE_INRUSH_CYC_P = pfc_pkg::DEBOUNCE_INRUSH_CYC,
   parameter int STARTUP_CYC_P = pfc_pkg::STARTUP_CYC,
   parameter int SHORT_CHECK_CYC_P = pfc_pkg::SHORT_CHECK_CYC
) (
   // Clock, reset and clock enable.
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Comparator levels from the analog front end, asynchronous.
   input wire logic biasAboveStart,
   input wire logic biasAboveStop,
   input wire logic refAboveUv,
   input wire logic refShort,
   input wire logic refCapValid,
   input wire logic refCapLarge,
   input wire logic pinTestPass,
   input wire logic fbValid,
   input wire logic overTemp,
   input wire logic lineAboveStart,
   input wire logic lineAboveDrop,
   input wire logic lineAboveDropInrush,
   input wire logic lineAboveDropSquare,
   input wire logic lineAboveHighEnter,
   input wire logic zeroCross,
   input wire logic currentAtLimit,
   input wire logic fbOverVolt,
   input wire logic fbBelowOvHyst,
   input wire logic shortSuspect,
   input wire logic shortConfirm,
   // Digital peak detector and switch driver, same clock.
   input wire logic peakStrobe,
   input wire logic [pfc_pkg::PEAK_W-1:0] linePeak,
   input wire logic [pfc_pkg::PEAK_W-1:0] lineAvg,
   input wire logic gateOn,
   // Control outputs.
   output logic switchEnable,
   output logic fullPowerMode,
   output logic highLineMode,
   output logic lowLineLimitSel,
   output logic currentTrip,
   output logic forceOff,
   output logic errHalfPull,
   output logic [7:0] errLimit
);
   import pfc_pkg::*;

   localparam int STEP_RAW = SOFT_STOP_CYC_P / int'(ERR_MAX);
   localparam int STEP_CYC = (STEP_RAW < 1) ? 1 : STEP_RAW;
   localparam int PW = PEAK_W + SQ_SHIFT;

   ////////////////////////////////////////////////////////////////////////
   logic [19:0] pinRaw;
   logic [19:0] pinSync;
   logic sBiasStart, sBiasStop, sRefOk, sRefShort, sCapValid, sCapLarge;
   logic sPins, sFbValid, sOverTemp, sLineStart, sLineDrop, sLineInrush;
   logic sLineSquare, sLineHigh, sZero, sCurLimit, sOverVolt, sOvLow;
   logic sSuspect, sConfirm;

   assign pinRaw = {biasAboveStart, biasAboveStop, refAboveUv, refShort,
      refCapValid, refCapLarge, pinTestPass, fbValid, overTemp,
      lineAboveStart, lineAboveDrop, lineAboveDropInrush,
      lineAboveDropSquare, lineAboveHighEnter, zeroCross, currentAtLimit,
      fbOverVolt, fbBelowOvHyst, shortSuspect, shortConfirm};

   pin_sync #(.W(20)) uSync (
      .core_clk(core_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .raw(pinRaw),
      .synced(pinSync)
   );

   assign {sBiasStart, sBiasStop, sRefOk, sRefShort, sCapValid, sCapLarge,
      sPins, sFbValid, sOverTemp, sLineStart, sLineDrop, sLineInrush,
      sLineSquare, sLineHigh, sZero, sCurLimit, sOverVolt, sOvLow,
      sSuspect, sConfirm} = pinSync;

   ////////////////////////////////////////////////////////////////////////
   state_e state_ff;
   logic [2:0] ctrl_ff;
   logic [PEAK_W-1:0] lowThr_ff, highThr_ff, lastPeak_ff;
   logic [FAULT_W-1:0] fault_ff;
   logic zeroD_ff, startupActive_ff, dipped_ff, squareWave_ff, ovHold_ff;
   logic checking_ff, soaOff_ff;
   logic [1:0] lowCnt_ff;
   logic [TMR_W-1:0] stepCnt_ff;
   logic running, active, lineOk, zcPulse, brownDone, startDone, dropDone;
   logic blankDone, soaOnDone, soaOffDone, checkDone, shortFault;
   logic hardFault, restartStart, brownOut, tripNow, soaEvent;
   logic busAccess, busWrite, mapped;

   assign running = (state_ff == S_RUN);
   assign active = running || state_ff == S_STOPWAIT
      || state_ff == S_SOFTSTOP;
   assign zcPulse = sZero && !zeroD_ff;

   // Brown-out threshold: in-rush window first, then square or normal.
   assign lineOk = startupActive_ff ? sLineInrush
      : (squareWave_ff ? sLineSquare : sLineDrop);
   assign restartStart = startupActive_ff && lineOk && dipped_ff;
   assign brownOut = running && brownDone;
   assign shortFault = checking_ff && sConfirm;

   // Reference undervoltage is awaited in S_REF, a fault afterwards.
   assign hardFault = (state_ff != S_BIAS) && (!sBiasStop
      || sRefShort
      || (state_ff != S_REF && !sRefOk)
      || shortFault);

   ////////////////////////////////////////////////////////////////////////
   // The normal debounce must outlast a half-cycle at 47 Hz, so that
   // one missing half-cycle only restarts the count.
   event_timer #(.W(TMR_W)) uBrown (
      .core_clk(core_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .clear(!running || lineOk || (startupActive_ff && startDone)),
      .run(running && !lineOk),
      .limit(startupActive_ff ? TMR_W'(DEBOUNCE_INRUSH_CYC_P)
         : TMR_W'(DEBOUNCE_CYC_P)),
      .done(brownDone)
   );

   event_timer #(.W(TMR_W)) uStartup (
      .core_clk(core_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .clear(!running || restartStart),
      .run(startupActive_ff),
      .limit(TMR_W'(STARTUP_CYC_P)),
      .done(startDone)
   );

   event_timer #(.W(TMR_W)) uDropout (
      .core_clk(core_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .clear(peakStrobe || !highLineMode),
      .run(highLineMode),
      .limit(TMR_W'(DROPOUT_CYC_P)),
      .done(dropDone)
   );

   event_timer #(.W(TMR_W)) uBlank (
      .core_clk(core_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .clear(!gateOn),
      .run(gateOn),
      .limit(TMR_W'(BLANK_CYC)),
      .done(blankDone)
   );

   event_timer #(.W(TMR_W)) uSoaOn (
      .core_clk(core_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .clear(!gateOn),
      .run(gateOn),
      .limit(TMR_W'(SOA_ON_CYC)),
      .done(soaOnDone)
   );

   event_timer #(.W(TMR_W)) uSoaOff (
      .core_clk(core_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .clear(!soaOff_ff),
      .run(soaOff_ff),
      .limit(TMR_W'(SOA_OFF_CYC - 1)),
      .done(soaOffDone)
   );

   event_timer #(.W(TMR_W)) uCheck (
      .core_clk(core_clk),
      .nrst(nrst),
      .clkEn(clkEn),
      .clear(!checking_ff),
      .run(checking_ff),
      .limit(TMR_W'(SHORT_CHECK_CYC_P)),
      .done(checkDone)
   );

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= S_BIAS;
      end else if (clkEn) begin
         if (hardFault) begin
            state_ff <= S_BIAS;
         end else begin
            case (state_ff)
               S_BIAS: if (sBiasStart) state_ff <= S_REF;
               S_REF: if (sRefOk) state_ff <= S_MODE;
               S_MODE: if (sCapValid) state_ff <= S_PINS;
               S_PINS: if (sPins) state_ff <= S_FB;
               S_FB: if (sFbValid) state_ff <= S_TEMP;
               S_TEMP: if (!sOverTemp) state_ff <= S_LINE;
               S_LINE: begin
                  if (sLineStart && lastPeak_ff <= PEAK_MAX_START) begin
                     state_ff <= S_RUN;
                  end
               end
               S_RUN: if (brownOut) state_ff <= S_STOPWAIT;
               S_STOPWAIT: if (zcPulse) state_ff <= S_SOFTSTOP;
               S_SOFTSTOP: if (errLimit == 8'h00) state_ff <= S_BIAS;
               default: state_ff <= S_BIAS;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fullPowerMode <= 1'b0;
      end else if (clkEn && state_ff == S_MODE && sCapValid) begin
         fullPowerMode <= sCapLarge;
      end
   end

   // Soft shutdown: the error limit walks from full scale to zero.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         errLimit <= ERR_MAX;
         stepCnt_ff <= '0;
      end else if (clkEn) begin
         if (state_ff != S_SOFTSTOP) begin
            errLimit <= ERR_MAX;
            stepCnt_ff <= '0;
         end else if (stepCnt_ff == TMR_W'(STEP_CYC - 1)) begin
            stepCnt_ff <= '0;
            if (errLimit != 8'h00) errLimit <= errLimit - 8'h01;
         end else begin
            stepCnt_ff <= stepCnt_ff + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         startupActive_ff <= 1'b0;
         dipped_ff <= 1'b0;
         zeroD_ff <= 1'b0;
      end else if (clkEn) begin
         zeroD_ff <= sZero;
         dipped_ff <= startupActive_ff && !lineOk;
         if (state_ff == S_LINE) begin
            startupActive_ff <= 1'b1;
         end else if (!running || startDone) begin
            startupActive_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         lastPeak_ff <= '0;
         squareWave_ff <= 1'b0;
      end else if (clkEn && peakStrobe) begin
         lastPeak_ff <= linePeak;
         squareWave_ff <= ({lineAvg, SQ_SHIFT'(0)}
            >= PW'(SQ_NUM) * PW'(linePeak));
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         highLineMode <= 1'b0;
         lowCnt_ff <= 2'h0;
      end else if (clkEn) begin
         if (!ctrl_ff[CTRL_UNIV_BIT]) begin
            highLineMode <= 1'b1;
            lowCnt_ff <= 2'h0;
         end else if (ctrl_ff[CTRL_FOLLOW_BIT] && sLineHigh) begin
            highLineMode <= 1'b1;
            lowCnt_ff <= 2'h0;
         end else if (dropDone) begin
            highLineMode <= 1'b0;
            lowCnt_ff <= 2'h0;
         end else if (peakStrobe) begin
            if (linePeak > highThr_ff) begin
               highLineMode <= 1'b1;
               lowCnt_ff <= 2'h0;
            end else if (linePeak < lowThr_ff) begin
               if (lowCnt_ff == LOW_PEAK_COUNT - 2'h1) begin
                  highLineMode <= 1'b0;
               end
               if (lowCnt_ff != LOW_PEAK_COUNT) lowCnt_ff <= lowCnt_ff + 2'h1;
            end else begin
               lowCnt_ff <= 2'h0;
            end
         end
      end
   end

   assign lowLineLimitSel = !highLineMode;

   ////////////////////////////////////////////////////////////////////////
   // Blanking hides the turn-on spike; comparator lag is two cycles.
   assign tripNow = gateOn && blankDone && sCurLimit && active;
   assign soaEvent = tripNow && !soaOnDone;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         currentTrip <= 1'b0;
         errHalfPull <= 1'b0;
         soaOff_ff <= 1'b0;
      end else if (clkEn) begin
         currentTrip <= tripNow;
         errHalfPull <= soaEvent;
         if (soaEvent) begin
            soaOff_ff <= 1'b1;
         end else if (soaOffDone) begin
            soaOff_ff <= 1'b0;
         end
      end
   end

   assign forceOff = soaOff_ff;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ovHold_ff <= 1'b0;
         checking_ff <= 1'b0;
      end else if (clkEn) begin
         if (sOverVolt) begin
            ovHold_ff <= 1'b1;
         end else if (sOvLow) begin
            ovHold_ff <= 1'b0;
         end
         if (state_ff == S_BIAS || checkDone) begin
            checking_ff <= 1'b0;
         end else if (sSuspect) begin
            checking_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         switchEnable <= 1'b0;
      end else if (clkEn) begin
         switchEnable <= active && !hardFault && ctrl_ff[CTRL_EN_BIT]
            && !ovHold_ff && !soaOff_ff && errLimit != 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Zero-wait APB slave; read data is captured in the setup cycle.
   assign busAccess = psel && penable && clkEn;
   assign busWrite = busAccess && pwrite && mapped;
   assign mapped = paddr == CTRL_OFS || paddr == THRESH_OFS
      || paddr == STATUS_OFS || paddr == FAULT_OFS;
   assign pready = clkEn;
   assign pslverr = psel && penable && !mapped;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_ff <= CTRL_RST;
         lowThr_ff <= PEAK_LOW_RST;
         highThr_ff <= PEAK_HIGH_RST;
      end else if (busWrite) begin
         if (paddr == CTRL_OFS) ctrl_ff <= pwdata[2:0];
         if (paddr == THRESH_OFS) begin
            lowThr_ff <= pwdata[THR_LOW_LSB +: PEAK_W];
            highThr_ff <= pwdata[THR_HIGH_LSB +: PEAK_W];
         end
      end
   end

   // Hardware sets win over a write-one clear in the same cycle.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fault_ff <= '0;
      end else if (clkEn) begin
         fault_ff <= (fault_ff & ~((busWrite && paddr == FAULT_OFS)
            ? pwdata[FAULT_W-1:0] : FAULT_W'(0)))
            | {soaEvent, sOverVolt, shortFault,
               state_ff != S_BIAS && !sBiasStop,
               hardFault && state_ff != S_REF && !sRefOk,
               state_ff != S_BIAS && sRefShort, brownOut};
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
      end else if (clkEn && psel && !penable) begin
         case (paddr)
            CTRL_OFS: prdata <= {29'h0, ctrl_ff};
            THRESH_OFS: prdata <= {6'h0, highThr_ff, 6'h0, lowThr_ff};
            STATUS_OFS: prdata <= {20'h0, lowLineLimitSel, switchEnable,
               startupActive_ff, ovHold_ff, squareWave_ff, highLineMode,
               fullPowerMode, 1'b0, state_ff};
            FAULT_OFS: prdata <= {25'h0, fault_ff};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule // pfc_protection_supervisor

// ### common/pfc_pkg.sv
// Shared constants and types for the PFC protection supervisor.
package pfc_pkg;
   // Clock and derived units.
   localparam int CLK_MHZ = 50;
   localparam int CLK_KHZ = CLK_MHZ * 1000;
   // Documented times.
   localparam int SOFT_STOP_US = 1000;
   localparam int DROPOUT_MS = 37;
   // Times that are not documented; plain defaults.
   localparam int DEBOUNCE_MS = 25;
   localparam int DEBOUNCE_INRUSH_MS = 100;
   localparam int STARTUP_MS = 500;
   localparam int BLANK_NS = 200;
   localparam int SOA_ON_NS = 1000;
   localparam int SOA_OFF_NS = 5000;
   localparam int SHORT_CHECK_US = 10;
   // Cycle counts; least times round up.
   localparam int SOFT_STOP_CYC = SOFT_STOP_US * CLK_MHZ;
   localparam int DROPOUT_CYC = DROPOUT_MS * CLK_KHZ;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
   localparam int DEBOUNCE_INRUSH_CYC = DEBOUNCE_INRUSH_MS * CLK_KHZ;
   localparam int STARTUP_CYC = STARTUP_MS * CLK_KHZ;
   localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int SOA_ON_CYC = (SOA_ON_NS * CLK_MHZ + 999) / 1000;
   localparam int SOA_OFF_CYC = (SOA_OFF_NS * CLK_MHZ + 999) / 1000;
   localparam int SHORT_CHECK_CYC = SHORT_CHECK_US * CLK_MHZ;
   localparam int TMR_W = 26;
   // Line peak codes, one LSB per volt of peak.
   localparam int PEAK_W = 10;
   localparam logic [9:0] PEAK_MAX_START = 10'h190;
   localparam logic [9:0] PEAK_LOW_RST = 10'h0c6;
   localparam logic [9:0] PEAK_HIGH_RST = 10'h0f0;
   localparam logic [1:0] LOW_PEAK_COUNT = 2'h3;
   // Square wave when average reaches seven eighths of the peak.
   localparam int SQ_NUM = 7;
   localparam int SQ_SHIFT = 3;
   localparam logic [7:0] ERR_MAX = 8'hff;
   // Register map.
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] THRESH_OFS = 12'h004;
   localparam logic [11:0] STATUS_OFS = 12'h008;
   localparam logic [11:0] FAULT_OFS = 12'h00c;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_UNIV_BIT = 1;
   localparam int CTRL_FOLLOW_BIT = 2;
   localparam logic [2:0] CTRL_RST = 3'h7;
   localparam int THR_LOW_LSB = 0;
   localparam int THR_HIGH_LSB = 16;
   localparam int FAULT_W = 7;
   typedef enum logic [3:0] {
      S_BIAS, S_REF, S_MODE, S_PINS, S_FB, S_TEMP, S_LINE, S_RUN,
      S_STOPWAIT, S_SOFTSTOP
   } state_e;
endpackage

// ### rtl/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous comparator levels.
`timescale 1ns/1ns
module pin_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   // Levels.
   input wire logic [W-1:0] raw,
   output logic [W-1:0] synced
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= '0;
         synced <= '0;
      end else if (clkEn) begin
         meta_ff <= raw;
         synced <= meta_ff;
      end
   end
endmodule // pin_sync

// ### rtl/event_timer.sv
// Up-counter that reports when a running interval reaches its limit.
`timescale 1ns/1ns
module event_timer #(
   parameter int W = 26
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   // Control.
   input wire logic clear,
   input wire logic run,
   input wire logic [W-1:0] limit,
   output logic done
);
   logic [W-1:0] count_ff;

   // The count saturates at the limit so done holds until cleared.
   assign done = (count_ff >= limit);

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         count_ff <= '0;
      end else if (clkEn) begin
         if (clear) begin
            count_ff <= '0;
         end else if (run && !done) begin
            count_ff <= count_ff + 1'b1;
         end
      end
   end
endmodule // event_timer

// ### testbench/pfc_protection_supervisor_props.sv
// Port-level assertions for the PFC protection supervisor.
`timescale 1ns/1ns
module pfc_protection_supervisor_props (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clkEn,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   // Fault inputs and driver.
   input wire logic biasAboveStop,
   input wire logic refShort,
   input wire logic gateOn,
   // Control outputs.
   input wire logic switchEnable,
   input wire logic highLineMode,
   input wire logic lowLineLimitSel,
   input wire logic currentTrip,
   input wire logic forceOff,
   input wire logic errHalfPull,
   input wire logic [7:0] errLimit
);
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   a_low_line_inverse: assert property (lowLineLimitSel == !highLineMode)
      else $error("low-line select not inverse of high line");
   a_soft_stop_off: assert property (errLimit == 8'h00 |=> !switchEnable)
      else $error("switching with error limit at zero");
   a_err_ramp_step: assert property ($changed(errLimit) |->
      errLimit == $past(errLimit) - 8'h01 || errLimit == 8'hff)
      else $error("error limit jumped");
   a_force_off_span: assert property ($rose(forceOff) |->
      ##249 forceOff ##1 !forceOff)
      else $error("forced off-time not 250 cycles");
   a_half_pull_soa: assert property (errHalfPull |-> $rose(forceOff))
      else $error("half pull without safe-area event");
   a_blank_no_trip: assert property ($rose(gateOn) |=> !currentTrip[*8])
      else $error("trip inside blanking");
   a_bias_low_stop: assert property (!biasAboveStop[*6] |-> !switchEnable)
      else $error("switching with bias low");
   a_ref_short_stop: assert property (refShort[*6] |-> !switchEnable)
      else $error("switching with reference shorted");
   a_apb_ready: assert property (pready == clkEn)
      else $error("ready not equal to clock enable");
   a_bad_addr_err: assert property (psel && penable && paddr > 12'h00c
      |-> pslverr)
      else $error("unmapped access without error");
endmodule // pfc_protection_supervisor_props

bind pfc_protection_supervisor pfc_protection_supervisor_props props_i (.*);

// ### testbench/pfc_front_model.sv
// Peak detector and gate driver stand-in for the supervisor.
`timescale 1ns/1ns
module pfc_front_model #(
   parameter int HALF = 100
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   // Settings and feedback.
   input wire logic [9:0] peakSet,
   input wire logic gateRun,
   input wire logic forceOff,
   // To the supervisor.
   output logic peakStrobe,
   output logic [9:0] linePeak,
   output logic [9:0] lineAvg,
   output logic gateOn
);
   int cnt;
   // A half line cycle is scaled to HALF clocks to keep the run short.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
         peakStrobe <= 1'b0;
      end else begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         peakStrobe <= (cnt == HALF - 1);
      end
   end
   assign linePeak = peakSet;
   assign lineAvg = {1'b0, peakSet[9:1]};
   // A real driver obeys the forced off-time, so the model does too.
   assign gateOn = gateRun && cnt < 40 && !forceOff;
endmodule // pfc_front_model

// ### testbench/pfc_protection_supervisor_tb.sv
// Self-checking bench for the PFC protection supervisor.
`timescale 1ns/1ns
module pfc_protection_supervisor_tb;
   import pfc_pkg::*;
   logic core_clk, nrst, clkEn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic biasAboveStart, biasAboveStop, refAboveUv, refShort, refCapValid;
   logic refCapLarge, pinTestPass, fbValid, overTemp, lineAboveStart;
   logic lineAboveDrop, lineAboveDropInrush, lineAboveDropSquare;
   logic lineAboveHighEnter, zeroCross, currentAtLimit, fbOverVolt;
   logic fbBelowOvHyst, shortSuspect, shortConfirm, gateRun, sawOff, slv;
   logic peakStrobe, gateOn, switchEnable, fullPowerMode, highLineMode;
   logic lowLineLimitSel, currentTrip, forceOff, errHalfPull;
   logic [9:0] peakSet, linePeak, lineAvg;
   logic [7:0] errLimit;
   int errCount, nChecks, cyc, n;
   pfc_protection_supervisor #(.SOFT_STOP_CYC_P(510), .DROPOUT_CYC_P(400),
      .DEBOUNCE_CYC_P(300), .DEBOUNCE_INRUSH_CYC_P(600),
      .STARTUP_CYC_P(1000), .SHORT_CHECK_CYC_P(20))
      pfc_protection_supervisor_i (.*);
   pfc_front_model pfc_front_model_i (.*);
   task automatic chk(input string w, input logic [31:0] s, e);
      nChecks++;
      if (s !== e) begin
         errCount++;
         $display("CHECK FAILED %s exp %h seen %h", w, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge core_clk);
   endtask
   task automatic pk(input int c);
      repeat (c) @(posedge core_clk iff peakStrobe);
   endtask
   // Returns the cycles taken in n; the wait gives up after 3000 cycles.
   task automatic waitEn(input logic v);
      n = 0;
      while (switchEnable !== v && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
   endtask
   task automatic st(input logic [3:0] e);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("state", rd[3:0], e);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (forceOff === 1'b1) sawOff = 1'b1;
      cyc++;
      if (cyc == 20000) begin
         errCount++;
         tally_and_finish();
      end
   end
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata, sawOff, gateRun} = '0;
      {biasAboveStart, biasAboveStop, refAboveUv, refShort, refCapValid} = '0;
      {refCapLarge, pinTestPass, fbValid, overTemp, lineAboveStart} = '0;
      {lineAboveDrop, lineAboveDropInrush, lineAboveDropSquare} = '0;
      {lineAboveHighEnter, zeroCross, currentAtLimit, fbOverVolt} = '0;
      {fbBelowOvHyst, shortSuspect, shortConfirm} = '0;
      clkEn = 1'b1;
      peakSet = 10'd401;
      wt(16);
      nrst <= 1'b1;
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl", rd, {29'h0, CTRL_RST});
      apb(1'b0, THRESH_OFS, 32'h0);
      chk("thresh", rd, {6'h0, PEAK_HIGH_RST, 6'h0, PEAK_LOW_RST});
      apb(1'b1, 12'h010, 32'hffffffff);
      chk("slverr", slv, 1'b1);
      pk(1);
      {biasAboveStart, biasAboveStop, refAboveUv, refCapValid} <= 4'hf;
      {refCapLarge, pinTestPass, fbValid, lineAboveStart} <= 4'hf;
      {lineAboveDrop, lineAboveDropInrush, lineAboveDropSquare} <= 3'h7;
      wt(300);
      chk("peak over start", switchEnable, 1'b0);
      peakSet <= PEAK_MAX_START;
      waitEn(1'b1);
      chk("enable", switchEnable, 1'b1);
      chk("full power", fullPowerMode, 1'b1);
      st(4'h7);
      pk(1);
      peakSet <= 10'd150;
      pk(2);
      wt(5);
      chk("high after 2", highLineMode, 1'b1);
      pk(1);
      wt(5);
      chk("high after 3", highLineMode, 1'b0);
      chk("low limit", lowLineLimitSel, 1'b1);
      lineAboveHighEnter <= 1'b1;
      wt(6);
      chk("follower", highLineMode, 1'b1);
      lineAboveHighEnter <= 1'b0;
      currentAtLimit <= 1'b1;
      gateRun <= 1'b1;
      wt(300);
      {gateRun, currentAtLimit} <= 2'b00;
      chk("safe area", sawOff, 1'b1);
      wt(1000);
      lineAboveDrop <= 1'b0;
      wt(150);
      lineAboveDrop <= 1'b1;
      wt(400);
      chk("one dip", switchEnable, 1'b1);
      {lineAboveDrop, lineAboveStart} <= 2'b00;
      wt(400);
      st(4'h8);
      zeroCross <= 1'b1;
      wt(3);
      zeroCross <= 1'b0;
      wt(100);
      st(4'h9);
      waitEn(1'b0);
      chk("ramp long", n > 350, 1'b1);
      apb(1'b0, FAULT_OFS, 32'h0);
      chk("brownout flag", rd[0], 1'b1);
      wt(200);
      st(4'h6);
      {lineAboveDrop, lineAboveStart} <= 2'b11;
      waitEn(1'b1);
      chk("restart", switchEnable, 1'b1);
      lineAboveDrop <= 1'b0;
      wt(400);
      chk("inrush window", switchEnable, 1'b1);
      lineAboveDrop <= 1'b1;
      refShort <= 1'b1;
      wt(10);
      chk("ref short", switchEnable, 1'b0);
      refShort <= 1'b0;
      waitEn(1'b1);
      chk("requalified", switchEnable, 1'b1);
      fbOverVolt <= 1'b1;
      wt(6);
      chk("ov stop", switchEnable, 1'b0);
      fbOverVolt <= 1'b0;
      wt(6);
      chk("ov hold", switchEnable, 1'b0);
      fbBelowOvHyst <= 1'b1;
      wt(6);
      chk("ov resume", switchEnable, 1'b1);
      fbBelowOvHyst <= 1'b0;
      shortSuspect <= 1'b1;
      wt(4);
      shortConfirm <= 1'b1;
      wt(6);
      chk("short stop", switchEnable, 1'b0);
      {shortSuspect, shortConfirm} <= 2'b00;
      {biasAboveStart, biasAboveStop} <= 2'b00;
      wt(10);
      chk("bias low", switchEnable, 1'b0);
      st(4'h0);
      tally_and_finish();
   end
endmodule // pfc_protection_supervisor_tb
